// ===== include/apd_pkg.sv
// Package for the auto power-down unit: constants and carrier structs
package apd_pkg;

   // ----------------------------------------
   // Counter and field positions
   // ----------------------------------------
   localparam int         CNT_W       = 4;
   localparam logic [3:0] IDLE_LIMIT  = 4'hF;
   localparam logic [3:0] CNT_ZERO    = 4'h0;
   localparam int         FIRST_SPEED = 3;
   localparam int         FIRST_CLK_A = 4;
   localparam int         FIRST_CLK_M = 5;
   localparam int         SEC_ADDR    = 0;
   localparam int         SEC_CTL0    = 2;
   localparam int         SEC_CTL1    = 3;
   localparam int         SEC_CTL2    = 4;
   localparam int         SEC_STROBE  = 5;
   localparam int         SEC_WRH     = 6;
   localparam logic [7:0] REG_RESET   = 8'h00;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed
   {
      logic [7:0]  addr_lo;
      logic [15:0] data;
      logic [2:0]  bus_control_inputs;
      logic        address_strobe_input;
      logic        high_byte_write_input;
   } apd_bus_t;

   typedef struct packed
   {
      logic        enable;
      logic        strobe_pol;
   } apd_cfg_t;

   typedef enum logic { APD_RUN, APD_DOWN } apd_state_t;

endpackage

// ===== design/apd_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module apd_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         mclk_i,
   input  wire logic         sys_rst_i,
   // Data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta;

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         meta <= '0;
         q_o  <= '0;
      end
      else
      begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule

// ===== design/apd_unit.sv
// Auto power-down unit with power management registers and input blocking
`timescale 1ns/1ps
// Function
// [R1] Enabled with strobe idle: four-bit counter steps on input clock ticks.
// [R2] Fifteen idle input clock periods raise the power-down signal.
// [R3] Enabling the unit enables power-down entry with no other setting.
// [R4] Strobe pulsing again ends power-down.
// [R5] Chip select low or reset also ends power-down.
// [R6] Power-down deselects memories, blocks address/data to them and logic.
// [R7] Memories go standby in power-down; logic and ports stay active.
// [R8] Pins: I/O hold, address out undefined, data/peripheral tri-state.
// [R9] Clock blocking for logic never stops the power-down counter.
// [R10] Software-set blocking bits stop signals reaching both logic arrays.
// [R11] Chip select high puts memories in standby, blocks nothing else.
// [R12] First register speed bit default keeps high-speed mode on.
// [R13] Power-down leaves logic behaviour alone; only speed bit matters.
// [R14] Memories wake on input change, then return to standby.
// [R15] Other saving options come from the two registers, not power-down.
// [R16] Count only when enabled and strobe static at selected polarity level.
// [R17] First register: bit 3 speed, bits 4/5 clock off to array/cells.
// [R18] Second register bits 0,2-6 disconnect address byte and bus controls.
// [R19] Registers clear on power-on reset; warm reset, power-down keep them.
// [R20] Counter clears on strobe pulse, holds terminal count until exit.
module apd_unit (
   // Clock and resets
   input  wire logic             mclk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             warm_rst_i,
   // Configuration and register writes
   input  wire apd_pkg::apd_cfg_t cfg_i,
   input  wire logic             first_wr_i,
   input  wire logic             second_wr_i,
   input  wire logic [7:0]       reg_wdata_i,
   // Pins
   input  wire apd_pkg::apd_bus_t bus_i,
   input  wire logic             general_input_clock_i,
   input  wire logic             chip_sel_n_i,
   // Status
   output logic [7:0]            power_mgmt_reg_first_o,
   output logic [7:0]            power_mgmt_reg_second_o,
   output logic                  power_down_signal_o,
   output logic                  high_speed_o,
   // Gated inputs
   output apd_pkg::apd_bus_t     mem_bus_o,
   output apd_pkg::apd_bus_t     decode_logic_array_o,
   output apd_pkg::apd_bus_t     general_logic_array_o,
   output logic                  array_clk_en_o,
   output logic                  macrocell_clk_en_o,
   // Memory and pin control
   output logic                  mem_select_o,
   output logic                  mem_standby_o,
   output logic                  data_port_oe_o,
   output logic                  addr_out_valid_o
);
   // All checks in this module run on the system clock
   default clocking chk_clk @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);

   // ----------------------------------------
   // Pin synchronisation
   // ----------------------------------------
   localparam int SYNC_W = $bits(apd_pkg::apd_bus_t) + 3;
   apd_pkg::apd_bus_t bus_s;
   logic              clk_pin_s;
   logic              csn_s;
   logic              wrst_s;

   apd_sync #(.W(SYNC_W)) u_sync (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .d_i       ({bus_i, general_input_clock_i, chip_sel_n_i, warm_rst_i}),
      .q_o       ({bus_s, clk_pin_s, csn_s, wrst_s})
   );

   // ----------------------------------------
   // Edge detection on synchronised pins
   // ----------------------------------------
   logic   clk_pin_d;
   logic   strobe_d;
   logic   tick;
   logic   strobe_edge;
   apd_pkg::apd_bus_t bus_d;

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         clk_pin_d <= 1'b0;
         strobe_d  <= 1'b0;
         bus_d     <= '0;
      end
      else
      begin
         clk_pin_d <= clk_pin_s;
         strobe_d  <= bus_s.address_strobe_input;
         bus_d     <= bus_s;
      end
   end

   // Input clock is ungated here, so clock blocking cannot starve us
   assign tick        = clk_pin_s & ~clk_pin_d;        // [R9]
   assign strobe_edge = bus_s.address_strobe_input ^ strobe_d;

   // ----------------------------------------
   // Power management registers
   // ----------------------------------------
   // Only the synchronous system reset clears them; warm reset does not
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         power_mgmt_reg_first_o <= apd_pkg::REG_RESET;   // [R19]
      else if (first_wr_i)
         power_mgmt_reg_first_o <= reg_wdata_i;          // [R10]
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         power_mgmt_reg_second_o <= apd_pkg::REG_RESET;  // [R19]
      else if (second_wr_i)
         power_mgmt_reg_second_o <= reg_wdata_i;         // [R10]
   end

   // Speed bit clear means high-speed mode stays on
   assign high_speed_o =
      ~power_mgmt_reg_first_o[apd_pkg::FIRST_SPEED];    // [R12] [R13]

   // ----------------------------------------
   // Inactivity counter and power-down state
   // ----------------------------------------
   logic [3:0]          cnt;
   apd_pkg::apd_state_t state;
   logic                idle_level;
   logic                wake;

   assign idle_level = (bus_s.address_strobe_input == cfg_i.strobe_pol)
                       & ~strobe_edge;                  // [R16]
   assign wake = strobe_edge | ~csn_s | wrst_s;         // [R4] [R5]

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i || !cfg_i.enable || wake)
         cnt <= apd_pkg::CNT_ZERO;                      // [R16] [R20]
      else if (!idle_level)
         cnt <= apd_pkg::CNT_ZERO;                      // [R20]
      else if (tick && cnt != apd_pkg::IDLE_LIMIT)
         cnt <= cnt + 4'h1;                             // [R1]
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         state <= apd_pkg::APD_RUN;
      else
      begin
         case (state)
            apd_pkg::APD_RUN:
               // Enable alone arms entry
               if (cfg_i.enable && !wake &&
                   cnt == apd_pkg::IDLE_LIMIT)
                  state <= apd_pkg::APD_DOWN;           // [R2] [R3]
            apd_pkg::APD_DOWN:
               if (wake || !cfg_i.enable)
                  state <= apd_pkg::APD_RUN;            // [R4] [R5]
            default:
               state <= apd_pkg::APD_RUN;
         endcase
      end
   end

   assign power_down_signal_o = (state == apd_pkg::APD_DOWN);

   // ----------------------------------------
   // Input blocking toward logic arrays
   // ----------------------------------------
   // Blocking bits act regardless of power-down; power-down adds the
   // address/data block on top.
   apd_pkg::apd_bus_t logic_bus;
   logic [7:0]        sec;

   assign sec = power_mgmt_reg_second_o;

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         logic_bus <= '0;
      else
      begin
         logic_bus <= bus_s;
         if (power_down_signal_o)
         begin
            logic_bus.addr_lo <= logic_bus.addr_lo;     // [R6]
            logic_bus.data    <= logic_bus.data;        // [R6]
         end
         if (sec[apd_pkg::SEC_ADDR])
            logic_bus.addr_lo <= logic_bus.addr_lo;     // [R18]
         if (sec[apd_pkg::SEC_CTL0])
            logic_bus.bus_control_inputs[0] <=
               logic_bus.bus_control_inputs[0];         // [R18]
         if (sec[apd_pkg::SEC_CTL1])
            logic_bus.bus_control_inputs[1] <=
               logic_bus.bus_control_inputs[1];         // [R18]
         if (sec[apd_pkg::SEC_CTL2])
            logic_bus.bus_control_inputs[2] <=
               logic_bus.bus_control_inputs[2];         // [R18]
         if (sec[apd_pkg::SEC_STROBE])
            logic_bus.address_strobe_input <=
               logic_bus.address_strobe_input;          // [R18]
         if (sec[apd_pkg::SEC_WRH])
            logic_bus.high_byte_write_input <=
               logic_bus.high_byte_write_input;         // [R18]
      end
   end

   // Both arrays see the same gated view
   assign decode_logic_array_o  = logic_bus;             // [R10]
   assign general_logic_array_o = logic_bus;             // [R10]
   assign array_clk_en_o =
      ~power_mgmt_reg_first_o[apd_pkg::FIRST_CLK_A];     // [R17]
   assign macrocell_clk_en_o =
      ~power_mgmt_reg_first_o[apd_pkg::FIRST_CLK_M];     // [R17] [R15]

   // ----------------------------------------
   // Memory path and pin control
   // ----------------------------------------
   logic in_change;

   assign in_change = (bus_s != bus_d);

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         mem_bus_o <= '0;
      else if (!power_down_signal_o && in_change)
         mem_bus_o <= bus_s;                            // [R6] [R14]
   end

   // Chip select high only deselects memories
   assign mem_select_o  = csn_s ? 1'b0 : ~power_down_signal_o; // [R6] [R11]
   // Standby unless an input just changed while selected
   assign mem_standby_o = ~mem_select_o | ~in_change;  // [R7] [R14]
   assign data_port_oe_o   = ~power_down_signal_o;     // [R8]
   assign addr_out_valid_o = ~power_down_signal_o;     // [R8]

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_pdn_entry: assert property ( // [R2]
      (state == apd_pkg::APD_RUN && cnt == apd_pkg::IDLE_LIMIT
       && cfg_i.enable && !wake) |=> power_down_signal_o)
      else $error("power-down not entered at terminal count");
   chk_pdn_exit: assert property ( // [R4]
      (power_down_signal_o && wake) |=> !power_down_signal_o)
      else $error("power-down not left on wake");
   chk_csn_exit: assert property ( // [R5]
      (power_down_signal_o && !csn_s) |=> !power_down_signal_o)
      else $error("chip select low did not wake");
   chk_cnt_clear: assert property ( // [R20]
      strobe_edge |=> cnt == apd_pkg::CNT_ZERO)
      else $error("counter not cleared by strobe pulse");
   chk_cnt_hold: assert property ( // [R20]
      (cnt == apd_pkg::IDLE_LIMIT && cfg_i.enable && !wake && idle_level)
      |=> cnt == apd_pkg::IDLE_LIMIT)
      else $error("terminal count not held");
   chk_cnt_disabled: assert property ( // [R16]
      !cfg_i.enable |=> cnt == apd_pkg::CNT_ZERO)
      else $error("counter ran while disabled");
   chk_cnt_step: assert property ( // [R1]
      (cfg_i.enable && !wake && idle_level && tick
       && cnt != apd_pkg::IDLE_LIMIT) |=> cnt == $past(cnt) + 4'h1)
      else $error("counter failed to step on clock tick");
   chk_mem_desel: assert property ( // [R6]
      power_down_signal_o |-> !mem_select_o && !data_port_oe_o)
      else $error("memory selected in power-down");
   chk_mem_hold: assert property ( // [R6]
      power_down_signal_o[*2] |-> $stable(mem_bus_o))
      else $error("memory bus moved in power-down");
   chk_logic_hold: assert property ( // [R6]
      power_down_signal_o[*2] |-> $stable(logic_bus.addr_lo)
      && $stable(logic_bus.data))
      else $error("address or data reached the arrays in power-down");
   chk_csn_select: assert property ( // [R11]
      csn_s |-> !mem_select_o && mem_standby_o)
      else $error("memory active with chip select high");
   chk_speed_bit: assert property ( // [R12]
      (first_wr_i && reg_wdata_i[apd_pkg::FIRST_SPEED]) |=> !high_speed_o)
      else $error("speed bit write not applied");
endmodule

// ===== verif/apd_host_model.sv
// Bus-side model: drives the strobe, address, chip select and input clock
`timescale 1ns/1ps
module apd_host_model (
   // Clock
   input  wire logic         mclk_i,
   // Pins
   output apd_pkg::apd_bus_t bus_o,
   output logic              gclk_o,
   output logic              chip_sel_n_o
);
   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   initial
   begin
      bus_o        = '0;
      gclk_o       = 1'b0;
      chip_sel_n_o = 1'b1;
   end
   // Slow ticks: each level must outlast the two-flop synchroniser
   task automatic ticks(input int n);
      repeat (n)
      begin
         @(posedge mclk_i) gclk_o <= 1'b1;
         repeat (4) @(posedge mclk_i);
         gclk_o <= 1'b0;
         repeat (4) @(posedge mclk_i);
      end
      #1;
   endtask
   // Returns just after an edge so callers see settled outputs
   task automatic drive(input logic [7:0] a, input logic s);
      @(posedge mclk_i);
      bus_o.addr_lo              <= a;
      bus_o.address_strobe_input <= s;
      repeat (4) @(posedge mclk_i);
      #1;
   endtask
   task automatic side(input logic [2:0] c, input logic w,
                       input logic [15:0] d);
      @(posedge mclk_i);
      bus_o.bus_control_inputs    <= c;
      bus_o.high_byte_write_input <= w;
      bus_o.data                  <= d;
      repeat (4) @(posedge mclk_i);
      #1;
   endtask
   task automatic pulse();
      drive(bus_o.addr_lo, ~bus_o.address_strobe_input);
      drive(bus_o.addr_lo, ~bus_o.address_strobe_input);
   endtask
   task automatic csn(input logic v);
      @(posedge mclk_i) chip_sel_n_o <= v;
      repeat (4) @(posedge mclk_i);
      #1;
   endtask
endmodule

// ===== verif/apd_unit_tb.sv
// Self-checking bench for the auto power-down unit
`timescale 1ns/1ps
module apd_unit_tb;
   logic              mclk_i = 1'b0;
   logic              sys_rst_i = 1'b1;
   logic              warm_rst_i = 1'b0;
   apd_pkg::apd_cfg_t cfg_i = '0;
   logic              first_wr_i = 1'b0;
   logic              second_wr_i = 1'b0;
   logic [7:0]        reg_wdata_i = 8'h00;
   apd_pkg::apd_bus_t bus, mem_bus, dec_bus, gen_bus;
   logic              gclk, csn_n, pd, hs, a_en, m_en, sel, stby, oe, av;
   logic [7:0]        r1, r2;
   int                fail_count = 0;
   int                check_count = 0;

   always #20 mclk_i = ~mclk_i;

   apd_host_model p (.mclk_i(mclk_i), .bus_o(bus), .gclk_o(gclk),
      .chip_sel_n_o(csn_n));
   apd_unit uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .warm_rst_i(warm_rst_i), .cfg_i(cfg_i), .first_wr_i(first_wr_i),
      .second_wr_i(second_wr_i), .reg_wdata_i(reg_wdata_i), .bus_i(bus),
      .general_input_clock_i(gclk), .chip_sel_n_i(csn_n),
      .power_mgmt_reg_first_o(r1), .power_mgmt_reg_second_o(r2),
      .power_down_signal_o(pd), .high_speed_o(hs), .mem_bus_o(mem_bus),
      .decode_logic_array_o(dec_bus), .general_logic_array_o(gen_bus),
      .array_clk_en_o(a_en), .macrocell_clk_en_o(m_en),
      .mem_select_o(sel), .mem_standby_o(stby), .data_port_oe_o(oe),
      .addr_out_valid_o(av));

   // ----------------------------------------
   // Access and check tasks
   // ----------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic wr(input logic sec, input logic [7:0] d);
      @(posedge mclk_i);
      first_wr_i  <= ~sec;
      second_wr_i <= sec;
      reg_wdata_i <= d;
      @(posedge mclk_i);
      first_wr_i  <= 1'b0;
      second_wr_i <= 1'b0;
      step(1);
   endtask
   task automatic cfg(input logic en, input logic pol);
      @(posedge mclk_i) cfg_i <= '{enable: en, strobe_pol: pol};
      step(3);
   endtask
   // Bounded wait: a hang ends the run as a failure
   task automatic wait_pd(input logic exp, input int lim);
      int n;
      n = 0;
      while (pd !== exp && n < lim)
      begin
         step(1);
         n++;
      end
      chk("power_down", pd, exp);
      if (pd !== exp)
         end_sim();
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (20) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      step(4);
      chk("reg_first", r1, 8'h00);
      chk("reg_second", r2, 8'h00);
      chk("high_speed", hs, 1'b1);
      chk("array_clk", {a_en, m_en}, 2'b11);
      wr(1'b0, 8'h38);
      chk("high_speed", hs, 1'b0);
      chk("array_clk", {a_en, m_en}, 2'b00);
      // Entry with logic clocks blocked: counter must still run
      p.drive(8'h11, 1'b1);
      cfg(1'b1, 1'b1);
      p.ticks(14);
      step(6);
      chk("pd_early", pd, 1'b0);
      p.ticks(1);
      wait_pd(1'b1, 10);
      chk("mem_select", sel, 1'b0);
      chk("mem_standby", stby, 1'b1);
      chk("pins_oe", {oe, av}, 2'b00);
      chk("reg_first", r1, 8'h38);
      chk("high_speed_pd", hs, 1'b0);
      // Address, data and controls move while powered down
      p.drive(8'h22, 1'b1);
      p.side(3'b101, 1'b1, 16'ha5c3);
      chk("gen_addr", gen_bus.addr_lo, 8'h11);
      chk("gen_data", gen_bus.data, 16'h0000);
      chk("mem_addr", mem_bus.addr_lo, 8'h11);
      chk("mem_data", mem_bus.data, 16'h0000);
      chk("gen_ctl_pd", gen_bus.bus_control_inputs, 3'b101);
      chk("pd_side", pd, 1'b1);
      p.pulse();
      wait_pd(1'b0, 10);
      step(3);
      chk("gen_addr", gen_bus.addr_lo, 8'h22);
      chk("gen_data", gen_bus.data, 16'ha5c3);
      chk("mem_addr", mem_bus.addr_lo, 8'h22);
      p.ticks(15);
      wait_pd(1'b1, 10);
      step(20);
      chk("pd_hold", pd, 1'b1);
      p.csn(1'b0);
      wait_pd(1'b0, 10);
      p.ticks(16);
      chk("pd_csn_low", pd, 1'b0);
      p.csn(1'b1);
      p.ticks(15);
      wait_pd(1'b1, 10);
      @(posedge mclk_i) warm_rst_i <= 1'b1;
      wait_pd(1'b0, 10);
      chk("reg_first", r1, 8'h38);
      @(posedge mclk_i) warm_rst_i <= 1'b0;
      cfg(1'b0, 1'b1);
      p.ticks(16);
      chk("pd_disabled", pd, 1'b0);
      cfg(1'b1, 1'b0);
      p.ticks(16);
      chk("pd_wrong_pol", pd, 1'b0);
      p.drive(8'h22, 1'b0);
      p.ticks(15);
      wait_pd(1'b1, 10);
      cfg(1'b0, 1'b0);
      wait_pd(1'b0, 10);
      // Second register blocking affects the arrays only
      wr(1'b1, 8'h7d);
      p.drive(8'h33, 1'b1);
      p.side(3'b010, 1'b0, 16'h0f0f);
      chk("dec_addr", dec_bus.addr_lo, 8'h22);
      chk("dec_strobe", dec_bus.address_strobe_input, 1'b0);
      chk("dec_ctl", dec_bus.bus_control_inputs, 3'b101);
      chk("gen_wrh", gen_bus.high_byte_write_input, 1'b1);
      chk("dec_data", dec_bus.data, 16'h0f0f);
      chk("mem_addr", mem_bus.addr_lo, 8'h33);
      chk("mem_ctl", mem_bus.bus_control_inputs, 3'b010);
      wr(1'b1, 8'h00);
      step(3);
      chk("dec_addr", dec_bus.addr_lo, 8'h33);
      chk("dec_strobe", dec_bus.address_strobe_input, 1'b1);
      chk("gen_ctl", gen_bus.bus_control_inputs, 3'b010);
      chk("dec_wrh", dec_bus.high_byte_write_input, 1'b0);
      chk("mem_select", sel, 1'b0);
      p.drive(8'h44, 1'b0);
      chk("gen_addr", gen_bus.addr_lo, 8'h44);
      p.csn(1'b0);
      chk("mem_select", sel, 1'b1);
      chk("mem_standby", stby, 1'b1);
      end_sim();
   end
endmodule
